// [hdl/trs_pkg.sv]
// Shared constants, state and mode types for the transceiver reset sequencer.
// Assumes one 100 MHz system clock drives both ends of the link.
package trs_pkg;
  // ****************************************
  // Link shape and clock
  // ****************************************
  localparam int NUM_CH = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TW = 16;

  // ****************************************
  // Minimum waits, in nanoseconds, and their cycle counts
  // ****************************************
  localparam int PLL_RST_NS = 1000;
  localparam int AUTO_DATA_SETTLE_NS = 4000;
  localparam int MANUAL_REF_TO_DATA_WAIT_NS = 2000;
  localparam int MANUAL_DATA_SETTLE_NS = 4000;
  localparam logic [TW-1:0] PLL_RST_CYC = TW'((PLL_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TW-1:0] AUTO_SETTLE_CYC = TW'((AUTO_DATA_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TW-1:0] REF_TO_DATA_CYC = TW'((MANUAL_REF_TO_DATA_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TW-1:0] DATA_SETTLE_CYC = TW'((MANUAL_DATA_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TW-1:0] FE_GAP_CYC = 16'h0002;

  // ****************************************
  // Transceiver model timing, in cycles
  // ****************************************
  localparam logic [7:0] PLL_LOCK_CYC = 8'h32;
  localparam logic [7:0] BUSY_CYC = 8'h14;
  localparam logic [7:0] FL_BASE_CYC = 8'h1e;
  localparam logic [7:0] FL_STEP_CYC = 8'h07;

  // ****************************************
  // Controller register map
  // ****************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_START = 0;
  localparam int CTRL_MANUAL = 1;
  localparam int CTRL_TX_ONLY = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  typedef enum logic [1:0] {BOND_TX_X2, BOND_TX_X4, BOND_XAUI} trs_bond_e;
  typedef enum logic [1:0] {LOCK_AUTO, LOCK_REF, LOCK_DATA} trs_lock_e;
  typedef enum logic [2:0] {
    ST_PLL_RST, ST_WAIT_BUSY, ST_GAP, ST_WAIT_LOCK, ST_AUTO_SETTLE, ST_MAN_REF, ST_MAN_DATA, ST_DONE
  } trs_state_e;
endpackage

// [hdl/trs_link_if.sv]
// Reset and status wires between the fabric reset controller and the bonded transceiver group.
// Both ends run on the same system clock; no clocking block is used.
`timescale 1ns/100ps
`default_nettype none
interface trs_link_if;
  logic mpll_async_reset;
  logic transmit_logic_reset;
  logic receive_frontend_reset;
  logic receive_logic_reset;
  logic cdr_force_ref_lock;
  logic cdr_force_data_lock;
  logic mpll_lock_flag;
  logic busy;
  logic [trs_pkg::NUM_CH-1:0] cdr_frequency_lock;

  modport xcvr (
    input mpll_async_reset, transmit_logic_reset, receive_frontend_reset, receive_logic_reset,
    input cdr_force_ref_lock, cdr_force_data_lock,
    output mpll_lock_flag, busy, cdr_frequency_lock
  );
  modport ctl (
    output mpll_async_reset, transmit_logic_reset, receive_frontend_reset, receive_logic_reset,
    output cdr_force_ref_lock, cdr_force_data_lock,
    input mpll_lock_flag, busy, cdr_frequency_lock
  );
endinterface
`default_nettype wire

// [hdl/trs_wait_timer.sv]
// Down-counter for the minimum waits of the reset controller.
// Assumes load is a one-cycle pulse; done reads high once the loaded count has fully elapsed.
`timescale 1ns/100ps
`default_nettype none
module trs_wait_timer (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic load, // Starts a new wait.
  input wire logic [trs_pkg::TW-1:0] cycles, // Length of the wait in cycles.
  output logic done // High when no wait is running.
);
  typedef struct packed {
    logic [trs_pkg::TW-1:0] cnt;
  } trs_tim_s;

  trs_tim_s s_q;
  trs_tim_s s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = cycles;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = (s_q.cnt == '0);
endmodule
`default_nettype wire

// [hdl/trs_reset_ctl.sv]
// Fabric reset controller for a bonded transceiver group, in automatic or manual CDR lock mode.
// Assumes the transceiver end shares clk_sys; frequency-lock inputs are still treated as asynchronous.
// Behaviour
// - Decode two lock inputs into three modes.
// - Manual mode tracks reference or data by inputs.
// - One shared reset set for all bonded channels.
// - XAUI bonds four lanes, each reporting lock.
// - Transmit-only bonds in two- or four-lane modes.
// - Hold PLL reset at least one microsecond.
// - Hold logic and receive resets during PLL reset.
// - Manual mode forces reference lock during reset.
// - PLL locks after reset release, raises flag.
// - Release transmit reset when PLL locks.
// - Two cycles after busy falls, release frontend.
// - Channel locks may rise at different times.
// - Auto: all locked, settle, release logic reset.
// - Manual: wait, then switch to data lock.
// - Manual: settle after data lock, release logic.
// - Busy pulses at power-up or reconfiguration only.
// - Busy low first cycle, high from second.
// - Use busy except for transmit-only setups.
`timescale 1ns/100ps
`default_nettype none
module trs_reset_ctl (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  trs_link_if.ctl link, // Reset and status wires to the transceiver group.
  input wire logic [3:0] addr, // Register byte address.
  input wire logic [31:0] wdata, // Register write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  output logic [31:0] rdata // Read data, valid the cycle after rd.
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    trs_pkg::trs_state_e st;
    logic pll_rst;
    logic tx_rst;
    logic fe_rst;
    logic lg_rst;
    logic ref_lk;
    logic data_lk;
    logic busy_seen;
    logic manual;
    logic tx_only;
    logic [2:0] ctrl;
    logic [trs_pkg::NUM_CH-1:0] fl_s1;
    logic [trs_pkg::NUM_CH-1:0] fl_s2;
    logic [31:0] rdata;
  } trs_ctl_s;

  trs_ctl_s s_q;
  trs_ctl_s s_d;
  logic tim_load;
  logic [trs_pkg::TW-1:0] tim_cycles;
  logic tim_done;
  logic all_locked;
  logic boot_q;

  trs_wait_timer trs_wait_timer_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(tim_load),
    .cycles(tim_cycles),
    .done(tim_done)
  );

  // Only the second synchroniser stage feeds the all-locked term.
  assign all_locked = &s_q.fl_s2;

  // ****************************************
  // Sequencer and register port
  // ****************************************
  always_comb begin
    s_d = s_q;
    tim_load = 1'b0;
    tim_cycles = '0;
    // The timer resets to idle, so the power-up PLL wait is loaded while the boot flop still holds the PLL reset.
    if (boot_q) begin
      tim_load = 1'b1;
      tim_cycles = trs_pkg::PLL_RST_CYC;
    end
    s_d.fl_s1 = link.cdr_frequency_lock;
    s_d.fl_s2 = s_q.fl_s1;
    // Busy seen once stays seen, so a later restart without reconfiguration traffic does not hang.
    if (link.busy) begin
      s_d.busy_seen = 1'b1;
    end
    // The transmit path leaves reset on lock regardless of where the receive side stands.
    if (!s_q.pll_rst && link.mpll_lock_flag) begin
      s_d.tx_rst = 1'b0;
    end
    case (s_q.st)
      trs_pkg::ST_PLL_RST: begin
        if (tim_done && !boot_q) begin
          s_d.pll_rst = 1'b0;
          s_d.st = s_q.tx_only ? trs_pkg::ST_DONE : trs_pkg::ST_WAIT_BUSY;
        end
      end
      trs_pkg::ST_WAIT_BUSY: begin
        if ((s_q.busy_seen || link.busy) && !link.busy) begin
          tim_load = 1'b1;
          tim_cycles = trs_pkg::FE_GAP_CYC;
          s_d.st = trs_pkg::ST_GAP;
        end
      end
      trs_pkg::ST_GAP: begin
        if (tim_done) begin
          s_d.fe_rst = 1'b0;
          tim_load = s_q.manual;
          tim_cycles = trs_pkg::REF_TO_DATA_CYC;
          s_d.st = s_q.manual ? trs_pkg::ST_MAN_REF : trs_pkg::ST_WAIT_LOCK;
        end
      end
      trs_pkg::ST_WAIT_LOCK: begin
        if (all_locked) begin
          tim_load = 1'b1;
          tim_cycles = trs_pkg::AUTO_SETTLE_CYC;
          s_d.st = trs_pkg::ST_AUTO_SETTLE;
        end
      end
      trs_pkg::ST_AUTO_SETTLE: begin
        if (!all_locked) begin
          s_d.st = trs_pkg::ST_WAIT_LOCK;
        end else if (tim_done) begin
          s_d.lg_rst = 1'b0;
          s_d.st = trs_pkg::ST_DONE;
        end
      end
      trs_pkg::ST_MAN_REF: begin
        if (tim_done) begin
          s_d.ref_lk = 1'b0;
          s_d.data_lk = 1'b1;
          tim_load = 1'b1;
          tim_cycles = trs_pkg::DATA_SETTLE_CYC;
          s_d.st = trs_pkg::ST_MAN_DATA;
        end
      end
      trs_pkg::ST_MAN_DATA: begin
        if (tim_done) begin
          s_d.lg_rst = 1'b0;
          s_d.st = trs_pkg::ST_DONE;
        end
      end
      default: begin
      end
    endcase
    s_d.rdata = '0;
    if (rd) begin
      if (addr == trs_pkg::REG_CTRL) begin
        s_d.rdata = {29'h0, s_q.ctrl};
      end else if (addr == trs_pkg::REG_STATUS) begin
        s_d.rdata = {18'h0, s_q.fl_s2, s_q.pll_rst, s_q.tx_rst, s_q.fe_rst, s_q.lg_rst,
                     s_q.ref_lk, s_q.data_lk, all_locked, s_q.st};
      end
    end
    if (wr && addr == trs_pkg::REG_CTRL) begin
      s_d.ctrl = wdata[2:0];
      s_d.ctrl[trs_pkg::CTRL_START] = 1'b0;
      if (wdata[trs_pkg::CTRL_START]) begin
        // A restart asserts every shared reset at once and takes the new mode bits.
        s_d.st = trs_pkg::ST_PLL_RST;
        s_d.pll_rst = 1'b1;
        s_d.tx_rst = 1'b1;
        s_d.fe_rst = 1'b1;
        s_d.lg_rst = 1'b1;
        s_d.manual = wdata[trs_pkg::CTRL_MANUAL];
        s_d.tx_only = wdata[trs_pkg::CTRL_TX_ONLY];
        s_d.ref_lk = wdata[trs_pkg::CTRL_MANUAL];
        s_d.data_lk = 1'b0;
        tim_load = 1'b1;
        tim_cycles = trs_pkg::PLL_RST_CYC;
      end
    end
  end

  // The power-up sequence starts from reset in automatic, receive-and-transmit mode.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '{st: trs_pkg::ST_PLL_RST, pll_rst: 1'b1, tx_rst: 1'b1, fe_rst: 1'b1, lg_rst: 1'b1,
               ref_lk: 1'b0, data_lk: 1'b0, busy_seen: 1'b0, manual: 1'b0, tx_only: 1'b0,
               ctrl: trs_pkg::CTRL_RESET, fl_s1: '0, fl_s2: '0, rdata: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // The first PLL wait after reset is loaded by this pulse, since the timer itself resets to idle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.mpll_async_reset = s_q.pll_rst | boot_q;
  assign link.transmit_logic_reset = s_q.tx_rst;
  assign link.receive_frontend_reset = s_q.fe_rst;
  assign link.receive_logic_reset = s_q.lg_rst;
  assign link.cdr_force_ref_lock = s_q.ref_lk;
  assign link.cdr_force_data_lock = s_q.data_lk;
  assign rdata = s_q.rdata;
endmodule
`default_nettype wire

// [hdl/trs_xcvr_end.sv]
// Behavioural transceiver group: shared PLL, offset-cancellation busy and four bonded CDR lanes.
// Assumes the controller drives the shared resets on clk_sys; lock times are fixed model delays.
`timescale 1ns/100ps
`default_nettype none
module trs_xcvr_end (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous power-up reset, active high.
  trs_link_if.xcvr link, // Reset and status wires from the controller.
  input wire trs_pkg::trs_bond_e bond_mode, // Bonded functional mode.
  input wire logic reconfig_access, // One-cycle reconfiguration read or write.
  output logic [trs_pkg::NUM_CH-1:0] lane_active, // Lanes bonded in this mode.
  output logic [trs_pkg::NUM_CH-1:0] tracks_ref, // Lane CDR follows the reference clock.
  output logic [trs_pkg::NUM_CH-1:0] tracks_data, // Lane CDR follows the serial data.
  output logic tx_ready, // Transmitter out of reset with PLL locked.
  output logic rx_ready // Receivers out of reset.
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic trs_pkg::trs_lock_e lock_mode(input logic ref_lock, input logic data_lock);
    if (data_lock) begin
      lock_mode = trs_pkg::LOCK_DATA;
    end else if (ref_lock) begin
      lock_mode = trs_pkg::LOCK_REF;
    end else begin
      lock_mode = trs_pkg::LOCK_AUTO;
    end
  endfunction

  function automatic logic [trs_pkg::NUM_CH-1:0] lanes(input trs_pkg::trs_bond_e m);
    lanes = (m == trs_pkg::BOND_TX_X2) ? 4'h3 : 4'hf;
  endfunction

  typedef struct packed {
    logic [7:0] pll_cnt;
    logic pll_lock;
    logic busy_pend;
    logic busy;
    logic [7:0] busy_cnt;
    logic [trs_pkg::NUM_CH-1:0][7:0] fl_cnt;
    logic [trs_pkg::NUM_CH-1:0] fl;
    logic [trs_pkg::NUM_CH-1:0] act;
    logic [trs_pkg::NUM_CH-1:0] t_ref;
    logic [trs_pkg::NUM_CH-1:0] t_data;
    logic tx_rdy;
    logic rx_rdy;
  } trs_xcvr_s;

  trs_xcvr_s s_q;
  trs_xcvr_s s_d;
  trs_pkg::trs_lock_e mode;
  logic xaui;

  assign mode = lock_mode(link.cdr_force_ref_lock, link.cdr_force_data_lock);
  assign xaui = (bond_mode == trs_pkg::BOND_XAUI);

  // ****************************************
  // PLL, busy and lanes
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (link.mpll_async_reset) begin
      s_d.pll_cnt = '0;
      s_d.pll_lock = 1'b0;
    end else if (!s_q.pll_lock) begin
      s_d.pll_cnt = s_q.pll_cnt + 1'b1;
      s_d.pll_lock = (s_q.pll_cnt == trs_pkg::PLL_LOCK_CYC - 1'b1);
    end
    // A pending pulse keeps busy low for one cycle before it rises.
    if (s_q.busy_pend) begin
      s_d.busy_pend = 1'b0;
      s_d.busy = 1'b1;
      s_d.busy_cnt = trs_pkg::BUSY_CYC;
    end else if (s_q.busy) begin
      s_d.busy_cnt = s_q.busy_cnt - 1'b1;
      s_d.busy = (s_q.busy_cnt != 8'h01);
    end
    if (reconfig_access && !s_q.busy) begin
      s_d.busy_pend = 1'b1;
    end
    s_d.act = lanes(bond_mode);
    for (int c = 0; c < trs_pkg::NUM_CH; c++) begin
      // Each lane locks after its own delay so the group never locks in one cycle.
      if (link.receive_frontend_reset || !xaui || mode == trs_pkg::LOCK_REF) begin
        s_d.fl_cnt[c] = '0;
        s_d.fl[c] = 1'b0;
      end else if (!s_q.fl[c]) begin
        s_d.fl_cnt[c] = s_q.fl_cnt[c] + 1'b1;
        s_d.fl[c] = (s_q.fl_cnt[c] == trs_pkg::FL_BASE_CYC + 8'(c) * trs_pkg::FL_STEP_CYC);
      end
      s_d.t_ref[c] = xaui && !link.receive_frontend_reset && mode == trs_pkg::LOCK_REF;
      s_d.t_data[c] = xaui && !link.receive_frontend_reset && (mode == trs_pkg::LOCK_DATA ||
                      (mode == trs_pkg::LOCK_AUTO && s_q.fl[c]));
    end
    s_d.tx_rdy = s_q.pll_lock && !link.transmit_logic_reset;
    s_d.rx_rdy = xaui && !link.receive_logic_reset && (&s_q.fl || mode == trs_pkg::LOCK_DATA);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.busy_pend <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.mpll_lock_flag = s_q.pll_lock;
  assign link.busy = s_q.busy;
  assign link.cdr_frequency_lock = s_q.fl;
  assign lane_active = s_q.act;
  assign tracks_ref = s_q.t_ref;
  assign tracks_data = s_q.t_data;
  assign tx_ready = s_q.tx_rdy;
  assign rx_ready = s_q.rx_rdy;
endmodule
`default_nettype wire

// [bench/trs_link_monitor.sv]
// Concurrent checks on the reset and status wires between the two ends of the link.
// Assumes one clock domain, clk_sys, with rst as its asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module trs_link_monitor (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic mpll_async_reset, // PLL reset.
  input wire logic transmit_logic_reset, // Transmit logic reset.
  input wire logic receive_frontend_reset, // Receive front-end reset.
  input wire logic receive_logic_reset, // Receive logic reset.
  input wire logic cdr_force_ref_lock, // Force reference lock.
  input wire logic cdr_force_data_lock, // Force data lock.
  input wire logic mpll_lock_flag, // PLL locked.
  input wire logic busy, // Offset cancellation busy.
  input wire logic [trs_pkg::NUM_CH-1:0] cdr_frequency_lock // Per-lane frequency lock.
);
  // ****************************************
  // Helper counters
  // ****************************************
  // Each counter holds how many consecutive cycles its condition has been sampled true.
  logic [15:0] pll_cnt_q;
  logic [15:0] lock_cnt_q;
  logic [15:0] fe_cnt_q;
  logic [15:0] dl_cnt_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pll_cnt_q <= 16'h0000;
      lock_cnt_q <= 16'h0000;
      fe_cnt_q <= 16'h0000;
      dl_cnt_q <= 16'h0000;
    end else begin
      pll_cnt_q <= mpll_async_reset ? pll_cnt_q + 16'h0001 : 16'h0000;
      lock_cnt_q <= (&cdr_frequency_lock) ? lock_cnt_q + 16'h0001 : 16'h0000;
      fe_cnt_q <= !receive_frontend_reset ? fe_cnt_q + 16'h0001 : 16'h0000;
      dl_cnt_q <= cdr_force_data_lock ? dl_cnt_q + 16'h0001 : 16'h0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_pll_hold_time: assert property ($fell(mpll_async_reset) |-> pll_cnt_q >= 16'h0064)
    else $error("PLL reset released too early");
  chk_resets_held: assert property (mpll_async_reset |->
      transmit_logic_reset && receive_frontend_reset && receive_logic_reset)
    else $error("reset released while PLL reset high");
  chk_no_data_lock: assert property (mpll_async_reset |-> !cdr_force_data_lock)
    else $error("data lock forced during PLL reset");
  chk_lock_decode: assert property (cdr_force_data_lock |-> !cdr_force_ref_lock)
    else $error("both lock controls high");
  chk_tx_after_lock: assert property ($fell(transmit_logic_reset) |-> $past(mpll_lock_flag))
    else $error("transmit reset dropped without PLL lock");
  chk_tx_prompt: assert property (mpll_lock_flag && !mpll_async_reset && transmit_logic_reset
      |=> !transmit_logic_reset || mpll_async_reset)
    else $error("transmit reset not dropped after PLL lock");
  chk_fe_gap: assert property ($fell(receive_frontend_reset) |->
      !$past(busy, 1) && !$past(busy, 2))
    else $error("front-end reset dropped within two cycles of busy");
  chk_ref_wait: assert property ($rose(cdr_force_data_lock) |->
      fe_cnt_q >= 16'h00c8 && $past(cdr_force_ref_lock))
    else $error("data lock forced too early");
  chk_auto_settle: assert property ($fell(receive_logic_reset) && !cdr_force_data_lock |->
      lock_cnt_q >= 16'h0190)
    else $error("logic reset dropped before auto settle");
  chk_man_settle: assert property ($fell(receive_logic_reset) && cdr_force_data_lock |->
      dl_cnt_q >= 16'h0190)
    else $error("logic reset dropped before data settle");
  chk_logic_order: assert property (!receive_logic_reset |-> !receive_frontend_reset)
    else $error("logic reset released before front-end reset");
endmodule
`default_nettype wire

// [bench/transceiver_reset_sequencer_tb.sv]
// Self-checking bench joining the reset controller and the transceiver group across one link.
// Assumes a 100 MHz clk_sys; registers are reached over the plain strobe port of the controller.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module transceiver_reset_sequencer_tb;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  trs_pkg::trs_bond_e bond_mode = trs_pkg::BOND_XAUI;
  logic reconfig_access = 1'b0;
  logic [3:0] lane_active;
  logic [3:0] tracks_ref;
  logic [3:0] tracks_data;
  logic tx_ready;
  logic rx_ready;
  logic [31:0] rv;
  int miscompares = 0;
  int cmp_count = 0;

  trs_link_if link ();
  trs_reset_ctl trs_reset_ctl_inst (.clk_sys(clk_sys), .rst(rst), .link(link), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  trs_xcvr_end trs_xcvr_end_inst (.clk_sys(clk_sys), .rst(rst), .link(link), .bond_mode(bond_mode),
    .reconfig_access(reconfig_access), .lane_active(lane_active), .tracks_ref(tracks_ref),
    .tracks_data(tracks_data), .tx_ready(tx_ready), .rx_ready(rx_ready));
  trs_link_monitor trs_link_monitor_inst (.clk_sys(clk_sys), .rst(rst),
    .mpll_async_reset(link.mpll_async_reset), .transmit_logic_reset(link.transmit_logic_reset),
    .receive_frontend_reset(link.receive_frontend_reset), .receive_logic_reset(link.receive_logic_reset),
    .cdr_force_ref_lock(link.cdr_force_ref_lock), .cdr_force_data_lock(link.cdr_force_data_lock),
    .mpll_lock_flag(link.mpll_lock_flag), .busy(link.busy), .cdr_frequency_lock(link.cdr_frequency_lock));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // A poll that never sees the wanted state counts as a mismatch instead of hanging.
  task automatic wait_state(input trs_pkg::trs_state_e st);
    int n;
    n = 0;
    reg_rd(trs_pkg::REG_STATUS, rv);
    while (rv[2:0] !== st && n < 2000) begin
      reg_rd(trs_pkg::REG_STATUS, rv);
      n++;
    end
    `CHECK(rv[2:0], st)
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    reg_rd(trs_pkg::REG_CTRL, rv);
    `CHECK(rv, 32'h00000000)
    reg_rd(4'h8, rv);
    `CHECK(rv, 32'h00000000)
    // Power-up runs by itself in automatic lock mode with all four lanes bonded.
    wait_state(trs_pkg::ST_DONE);
    reg_rd(trs_pkg::REG_STATUS, rv);
    `CHECK(rv, 32'h00003c0f)
    `CHECK({tx_ready, rx_ready, lane_active}, 6'h3f)
    reg_wr(trs_pkg::REG_STATUS, 32'h0000ffff);
    reg_rd(trs_pkg::REG_STATUS, rv);
    `CHECK(rv, 32'h00003c0f)
    // A reconfiguration access makes a new busy pulse, which ends while the manual restart still holds the PLL reset.
    @(posedge clk_sys);
    reconfig_access <= 1'b1;
    @(posedge clk_sys);
    reconfig_access <= 1'b0;
    reg_wr(trs_pkg::REG_CTRL, 32'h00000003);
    reg_rd(trs_pkg::REG_CTRL, rv);
    `CHECK(rv, 32'h00000002)
    wait_state(trs_pkg::ST_MAN_REF);
    `CHECK({tracks_ref, tracks_data}, 8'hf0)
    wait_state(trs_pkg::ST_DONE);
    reg_rd(trs_pkg::REG_STATUS, rv);
    `CHECK(rv, 32'h00003c1f)
    `CHECK({tracks_ref, tracks_data}, 8'h0f)
    // Transmit-only restart in two-lane bonding does not release the receivers.
    @(posedge clk_sys);
    bond_mode <= trs_pkg::BOND_TX_X2;
    reg_wr(trs_pkg::REG_CTRL, 32'h00000005);
    wait_state(trs_pkg::ST_DONE);
    // The end state comes with the PLL release, so the transmit reset drops only after the PLL lock time.
    repeat (int'(trs_pkg::PLL_LOCK_CYC) + 8) @(posedge clk_sys);
    reg_rd(trs_pkg::REG_STATUS, rv);
    `CHECK(rv, 32'h000000c7)
    `CHECK({tx_ready, rx_ready, lane_active}, 6'h23)
    @(posedge clk_sys);
    bond_mode <= trs_pkg::BOND_TX_X4;
    repeat (3) @(posedge clk_sys);
    `CHECK(lane_active, 4'hf)
    print_verdict();
  end

  // The three sequences need under two thousand cycles; this limit leaves ample room.
  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
